/* File: core/iscg_pkg.sv */
package iscg_pkg;

	localparam int NUM_CH = 2;

	// Register byte addresses
	localparam logic [31:0] GCID_0_ADDR = 32'hffff0828;
	localparam logic [31:0] CFG_0_ADDR  = 32'hffff082c;
	localparam logic [31:0] STAT_0_ADDR = 32'hffff0830;
	localparam logic [31:0] GCID_1_ADDR = 32'hffff0928;
	localparam logic [31:0] CFG_1_ADDR  = 32'hffff092c;
	localparam logic [31:0] STAT_1_ADDR = 32'hffff0930;

	// Reset values and writable mask
	localparam logic [31:0] CFG_RESET  = 32'h00000000;
	localparam logic [7:0]  GCID_RESET = 8'h00;
	localparam logic [31:0] CFG_WMASK  = 32'h00007fff;

	// Configuration field positions
	localparam int CFG_STOP_IE   = 14;
	localparam int CFG_STRETCH   = 11;
	localparam int CFG_TXREQ_DIS = 9;
	localparam int CFG_GC_CLR    = 8;
	localparam int CFG_HWGC_EN   = 4;
	localparam int CFG_GC_EN     = 3;

	// Status field positions
	localparam int STAT_GC        = 0;
	localparam int STAT_HWGC      = 1;
	localparam int STAT_ADDRESSED = 2;
	localparam int STAT_STRETCH   = 3;

	// General call codes
	localparam logic [7:0] GC_ADDR       = 8'h00;
	localparam logic [7:0] GC_CMD_RESET  = 8'h06;
	localparam logic [7:0] GC_CMD_REPROG = 8'h04;

	// Bit counter marks
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT      = 4'h9;

	// Software refill window for the transmit request
	localparam int REF_CLK_KHZ       = 41780;
	localparam int TXREQ_REF_CYCLES  = 45;
	localparam int SYS_CLK_KHZ       = 125000;
	localparam int TXREQ_SYS_CYCLES  = (TXREQ_REF_CYCLES * SYS_CLK_KHZ) / REF_CLK_KHZ;
	localparam int TXREQ_LATENCY     = 3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b11,
		ST_SKIP = 2'b10
	} iscg_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} iscg_pin_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} iscg_pin_out_t;

	typedef struct packed {
		logic stop_irq;
		logic tx_req;
		logic gc_reset;
		logic gc_reprog;
		logic gc_status;
		logic hwgc_status;
	} iscg_evt_t;

endpackage

/* File: core/iscg_top.sv */
// The APB register port was left to the implementer.
module iscg_top (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [31:0]            i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic      [31:0]            o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire iscg_pkg::iscg_pin_in_t i_pins    [iscg_pkg::NUM_CH],
	input  wire logic [6:0]             i_own_addr [iscg_pkg::NUM_CH],
	output iscg_pkg::iscg_pin_out_t     o_pins    [iscg_pkg::NUM_CH],
	output iscg_pkg::iscg_evt_t         o_evt     [iscg_pkg::NUM_CH]
);
	import iscg_pkg::*;

	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;
	logic               err_reg;
	logic               err_next;
	logic [31:0]        rd_mux;
	logic               hit;
	logic [NUM_CH-1:0]  sel_gcid;
	logic [NUM_CH-1:0]  sel_cfg;
	logic               wr_go;
	logic [7:0]         gcid_q [NUM_CH];
	logic [31:0]        cfg_q  [NUM_CH];
	logic [3:0]         stat_q [NUM_CH];

	// Zero wait states; read data is caught in the setup cycle
	assign o_pready  = 1'b1;
	assign o_prdata  = rdata_reg;
	assign o_pslverr = err_reg;
	assign wr_go     = i_psel & i_penable & i_pwrite & hit;

	always_comb begin
		hit      = 1'b1;
		sel_gcid = '0;
		sel_cfg  = '0;
		rd_mux   = '0;
		if (i_paddr == GCID_0_ADDR) begin
			sel_gcid[0] = 1'b1;
			rd_mux      = {24'h000000, gcid_q[0]};
		end else if (i_paddr == CFG_0_ADDR) begin
			sel_cfg[0] = 1'b1;
			rd_mux     = cfg_q[0];
		end else if (i_paddr == STAT_0_ADDR) begin
			rd_mux = {28'h0000000, stat_q[0]};
		end else if (i_paddr == GCID_1_ADDR) begin
			sel_gcid[1] = 1'b1;
			rd_mux      = {24'h000000, gcid_q[1]};
		end else if (i_paddr == CFG_1_ADDR) begin
			sel_cfg[1] = 1'b1;
			rd_mux     = cfg_q[1];
		end else if (i_paddr == STAT_1_ADDR) begin
			rd_mux = {28'h0000000, stat_q[1]};
		end else begin
			hit = 1'b0;
		end
	end

	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (i_psel && !i_penable) begin
			rdata_next = i_pwrite ? 32'h00000000 : rd_mux;
			err_next   = ~hit;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rdata_reg <= '0;
			err_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic        scl_s1, scl_s2, scl_d;
		logic        sda_s1, sda_s2, sda_d;
		logic        start_c, stop_c, scl_rise, scl_fall, active;
		iscg_state_t st_reg, st_next;
		logic [3:0]  cnt_reg, cnt_next;
		logic [7:0]  sh_reg, sh_next;
		logic        adr_reg, adr_next, isgc_reg, isgc_next, rd_reg, rd_next;
		logic        ack_reg, ack_next, str_reg, str_next;
		logic        gcs_reg, gcs_next, hwgc_reg, hwgc_next;
		logic        stop_reg, txr_reg, gcr_reg, rpg_reg;
		logic        stop_p, txr_p, gcr_p, rpg_p, gc_set, hw_set;
		logic [7:0]  gcid_reg, gcid_next;
		logic [31:0] cfg_reg, cfg_next;
		logic        wr_cfg;

		// First stage feeds only the second
		always_ff @(posedge i_sys_clk) begin
			if (!i_rst_n) begin
				{scl_s1, scl_s2, scl_d} <= 3'h7;
				{sda_s1, sda_s2, sda_d} <= 3'h7;
			end else begin
				{scl_s1, scl_s2, scl_d} <= {i_pins[g].scl, scl_s1, scl_s2};
				{sda_s1, sda_s2, sda_d} <= {i_pins[g].sda, sda_s1, sda_s2};
			end
		end

		assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
		assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;
		assign scl_rise = scl_s2 & ~scl_d;
		assign scl_fall = ~scl_s2 & scl_d;
		assign active   = (st_reg == ST_ADDR) || (st_reg == ST_DATA);
		assign wr_cfg   = wr_go & sel_cfg[g];

		always_comb begin
			st_next   = st_reg;
			cnt_next  = cnt_reg;
			sh_next   = sh_reg;
			adr_next  = adr_reg;
			isgc_next = isgc_reg;
			rd_next   = rd_reg;
			ack_next  = ack_reg;
			stop_p    = 1'b0;
			txr_p     = 1'b0;
			gcr_p     = 1'b0;
			rpg_p     = 1'b0;
			gc_set    = 1'b0;
			hw_set    = 1'b0;
			if (start_c) begin
				st_next   = ST_ADDR;
				cnt_next  = '0;
				adr_next  = 1'b0;
				isgc_next = 1'b0;
				ack_next  = 1'b0;
			end else if (stop_c) begin
				stop_p   = adr_reg & cfg_reg[CFG_STOP_IE];
				st_next  = ST_IDLE;
				adr_next = 1'b0;
				ack_next = 1'b0;
			end else if (active) begin
				if (scl_rise && cnt_reg < BITS_PER_BYTE) begin
					sh_next  = {sh_reg[6:0], sda_s2};
					cnt_next = cnt_reg + 4'h1;
				end
				if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
					cnt_next = ACK_SLOT;
					if (st_reg == ST_ADDR) begin
						if (sh_reg[7:1] == i_own_addr[g]) begin
							adr_next = 1'b1;
							rd_next  = sh_reg[0];
							ack_next = 1'b1;
							st_next  = ST_DATA;
							// Raised on the same fall that ends the read/write bit
							txr_p    = sh_reg[0] & ~cfg_reg[CFG_TXREQ_DIS];
						end else if (sh_reg == GC_ADDR && cfg_reg[CFG_GC_EN]) begin
							adr_next  = 1'b1;
							rd_next   = 1'b0;
							isgc_next = 1'b1;
							ack_next  = 1'b1;
							st_next   = ST_DATA;
						end else begin
							st_next = ST_SKIP;
						end
					end else begin
						ack_next = ~rd_reg;
						if (isgc_reg) begin
							gc_set = 1'b1;
							gcr_p  = (sh_reg == GC_CMD_RESET);
							rpg_p  = (sh_reg == GC_CMD_REPROG);
							hw_set = cfg_reg[CFG_HWGC_EN] & cfg_reg[CFG_GC_EN]
								& (sh_reg == gcid_reg);
						end
					end
				end else if (scl_fall && cnt_reg == ACK_SLOT) begin
					ack_next = 1'b0;
					cnt_next = '0;
				end
			end
		end

		always_comb begin
			// A new call in the clearing cycle is held one cycle, then cleared, unless both flags already read zero
			gcs_next  = gc_set | (gcs_reg & ~cfg_reg[CFG_GC_CLR]);
			hwgc_next = hw_set | (hwgc_reg & ~cfg_reg[CFG_GC_CLR]);
			// Only ever pulls a low line low, so no high phase is cut short
			str_next  = cfg_reg[CFG_STRETCH] & (str_reg | ~scl_s2);
			cfg_next  = cfg_reg;
			gcid_next = gcid_reg;
			if (cfg_reg[CFG_GC_CLR] && !gcs_reg && !hwgc_reg) begin
				cfg_next[CFG_GC_CLR] = 1'b0;
			end
			if (wr_cfg) begin
				cfg_next = i_pwdata & CFG_WMASK;
			end
			if (wr_go && sel_gcid[g]) begin
				gcid_next = i_pwdata[7:0];
			end
			if (gcr_p) begin
				cfg_next  = CFG_RESET;
				gcid_next = GCID_RESET;
			end
		end

		always_ff @(posedge i_sys_clk) begin
			if (!i_rst_n) begin
				st_reg   <= ST_IDLE;
				cnt_reg  <= '0;
				sh_reg   <= '0;
				adr_reg  <= 1'b0;
				isgc_reg <= 1'b0;
				rd_reg   <= 1'b0;
				ack_reg  <= 1'b0;
				str_reg  <= 1'b0;
				gcs_reg  <= 1'b0;
				hwgc_reg <= 1'b0;
				stop_reg <= 1'b0;
				txr_reg  <= 1'b0;
				gcr_reg  <= 1'b0;
				rpg_reg  <= 1'b0;
				cfg_reg  <= CFG_RESET;
				gcid_reg <= GCID_RESET;
			end else begin
				st_reg   <= st_next;
				cnt_reg  <= cnt_next;
				sh_reg   <= sh_next;
				adr_reg  <= adr_next;
				isgc_reg <= isgc_next;
				rd_reg   <= rd_next;
				ack_reg  <= ack_next;
				str_reg  <= str_next;
				gcs_reg  <= gcs_next;
				hwgc_reg <= hwgc_next;
				stop_reg <= stop_p;
				txr_reg  <= txr_p;
				gcr_reg  <= gcr_p;
				rpg_reg  <= rpg_p;
				cfg_reg  <= cfg_next;
				gcid_reg <= gcid_next;
			end
		end

		assign gcid_q[g] = gcid_reg;
		assign cfg_q[g]  = cfg_reg;
		assign stat_q[g] = {str_reg, adr_reg, hwgc_reg, gcs_reg};
		assign o_pins[g] = '{scl_o: 1'b0, scl_oe: str_reg, sda_o: 1'b0, sda_oe: ack_reg};
		assign o_evt[g]  = '{stop_irq: stop_reg, tx_req: txr_reg, gc_reset: gcr_reg,
			gc_reprog: rpg_reg, gc_status: gcs_reg, hwgc_status: hwgc_reg};

		property p_gcid_reset;
			!$past(i_rst_n) |-> gcid_reg == GCID_RESET;
		endproperty
		a_gcid_reset: assert property (p_gcid_reset) else $error("match id not zero after reset");

		property p_cfg_reset;
			!$past(i_rst_n) |-> cfg_reg == CFG_RESET && !str_reg;
		endproperty
		a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");

		property p_stop_irq;
			stop_reg |-> $past(cfg_reg[CFG_STOP_IE]) && $past(adr_reg) && $past(stop_c);
		endproperty
		a_stop_irq: assert property (p_stop_irq) else $error("stop interrupt without cause");

		property p_stretch_off;
			!cfg_reg[CFG_STRETCH] |=> !o_pins[g].scl_oe;
		endproperty
		a_stretch_off: assert property (p_stretch_off) else $error("SCL held while disabled");

		property p_stretch_start;
			$rose(str_reg) |-> $past(!scl_s2) && $past(cfg_reg[CFG_STRETCH]);
		endproperty
		a_stretch_start: assert property (p_stretch_start) else $error("stretch began on high SCL");

		property p_txreq;
			txr_reg |-> $past(scl_fall) && !$past(cfg_reg[CFG_TXREQ_DIS]) && $past(sh_reg[0]);
		endproperty
		a_txreq: assert property (p_txreq) else $error("transmit request without cause");

		// A matched read address must raise the request on the very next cycle
		property p_txreq_fast;
			scl_fall && st_reg == ST_ADDR && cnt_reg == BITS_PER_BYTE
				&& sh_reg[7:1] == i_own_addr[g] && sh_reg[0] && !cfg_reg[CFG_TXREQ_DIS]
				|=> txr_reg && TXREQ_LATENCY < TXREQ_SYS_CYCLES;
		endproperty
		a_txreq_fast: assert property (p_txreq_fast) else $error("transmit request too late");

		property p_reserved;
			cfg_reg[31:15] == 17'h00000;
		endproperty
		a_reserved: assert property (p_reserved) else $error("reserved config bits set");

		property p_hwgc;
			$rose(hwgc_reg) |-> $past(cfg_reg[CFG_HWGC_EN]) && $past(cfg_reg[CFG_GC_EN])
				&& $past(sh_reg) == $past(gcid_reg) && gcs_reg;
		endproperty
		a_hwgc: assert property (p_hwgc) else $error("hardware call flag without match");

		property p_gc_reset;
			gcr_reg |-> $past(sh_reg) == GC_CMD_RESET && gcs_reg && cfg_reg == CFG_RESET;
		endproperty
		a_gc_reset: assert property (p_gc_reset) else $error("general call reset wrong");

		property p_gc_clear;
			cfg_reg[CFG_GC_CLR] && !gcs_reg && !hwgc_reg && !wr_cfg |=> !cfg_reg[CFG_GC_CLR];
		endproperty
		a_gc_clear: assert property (p_gc_clear) else $error("clear bit did not self clear");

		c_stop: cover property (stop_reg);
		c_txreq: cover property (txr_reg);
		c_hwgc: cover property ($rose(hwgc_reg));
		c_stretch: cover property (str_reg ##1 !str_reg);
	end

endmodule // iscg_top

/* File: bench/iscg_bus_master.sv */
module iscg_bus_master (
	input  wire logic i_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_drv,
	output logic      o_sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 16;
	initial begin
		o_scl_drv = 1'b1;
		o_sda_drv = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic sclk(input logic v);
		o_scl_drv <= v;
		hold(HALF);
		// A stretching slave delays the high phase; the bench timeout ends a hang
		while (v && !i_scl) begin
			@(posedge i_clk);
		end
	endtask
	task automatic start();
		o_sda_drv <= 1'b0;
		hold(HALF);
		sclk(1'b0);
	endtask
	task automatic stop();
		o_sda_drv <= 1'b0;
		hold(HALF);
		sclk(1'b1);
		o_sda_drv <= 1'b1;
		hold(HALF);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda_drv <= b[i];
			hold(HALF);
			sclk(1'b1);
			sclk(1'b0);
		end
		o_sda_drv <= 1'b1;
		hold(HALF);
		sclk(1'b1);
		ack = !i_sda;
		sclk(1'b0);
	endtask
endmodule // iscg_bus_master

/* File: bench/tb_iscg_top.sv */
module tb_iscg_top;
	timeunit 1ns;
	timeprecision 1ps;
	import iscg_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ack, err, sclq = 1;
	logic [31:0]   paddr = 0, pwdata = 0, prdata, rd;
	logic          pready, pslverr, bscl, bsda;
	iscg_pin_in_t  pins [NUM_CH];
	iscg_pin_out_t pouts [NUM_CH];
	iscg_evt_t     evt [NUM_CH];
	logic [6:0]    own [NUM_CH] = '{7'h2a, 7'h15};
	logic [31:0]   mdl [4];
	logic [31:0]   adr [4] = '{GCID_0_ADDR, CFG_0_ADDR, GCID_1_ADDR, CFG_1_ADDR};
	logic [31:0]   msk [4] = '{32'hff, CFG_WMASK, 32'hff, CFG_WMASK};
	int            fails = 0, checks = 0, cyc = 0, n [4] = '{0, 0, 0, 0}, b [4];
	int            since = 0, lat = 1000;
	always #4 clk = ~clk;
	assign pins[0] = {bscl & ~pouts[0].scl_oe, bsda & ~pouts[0].sda_oe};
	assign pins[1] = 2'b11;
	iscg_top iscg_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pins(pins),
		.i_own_addr(own), .o_pins(pouts), .o_evt(evt));
	iscg_bus_master iscg_bus_master_inst (.i_clk(clk), .i_scl(pins[0].scl),
		.i_sda(pins[0].sda), .o_scl_drv(bscl), .o_sda_drv(bsda));
	always @(posedge clk) begin
		n[0] <= n[0] + evt[0].stop_irq;
		n[1] <= n[1] + evt[0].tx_req;
		n[2] <= n[2] + evt[0].gc_reset;
		n[3] <= n[3] + evt[0].gc_reprog;
		cyc <= cyc + 1;
		sclq <= pins[0].scl;
		// Cycles since the last SCL fall, latched at each transmit request
		since <= (sclq && !pins[0].scl) ? 0 : since + 1;
		if (evt[0].tx_req)
			lat <= since;
		// Cut a hang short
		if (cyc == 60000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the bench timeout ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never reassigns psel in this step
		@(posedge clk);
	endtask
	task automatic wr(input int i, input logic [31:0] d);
		apb(1'b1, adr[i], d);
		mdl[i] = d & msk[i];
	endtask
	task automatic rdchk(input int i);
		apb(1'b0, adr[i], 32'h0);
		chk(rd, mdl[i]);
	endtask
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic two);
		iscg_bus_master_inst.start();
		iscg_bus_master_inst.wbyte(a, ack);
		if (two)
			iscg_bus_master_inst.wbyte(d, err);
		iscg_bus_master_inst.stop();
	endtask
	initial begin
		logic [31:0] cfgs [3] = '{32'h200, 32'h4000, 32'h4200};
		logic [7:0] g;
		void'($urandom(32'hd58a));
		mdl = '{0, 0, 0, 0};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rdchk(i);
		apb(1'b0, 32'hffff0834, 32'h0);
		chk(err, 1'b1);
		$display("reset and map test done");
		repeat (8) for (int i = 0; i < 4; i++) begin
			// Reserved and self-clearing positions stay zero
			wr(i, $urandom & 32'h4afb);
			rdchk(i);
		end
		for (int i = 0; i < 4; i++) wr(i, 32'h0);
		$display("read back test done");
		wr(1, 32'h800);
		repeat (10) @(posedge clk);
		chk(pouts[0].scl_oe, 1'b0);
		iscg_bus_master_inst.start();
		chk(pouts[0].scl_oe, 1'b1);
		wr(1, 32'h0);
		repeat (4) @(posedge clk);
		chk(pouts[0].scl_oe, 1'b0);
		iscg_bus_master_inst.stop();
		$display("stretch test done");
		wr(1, 32'h8);
		frame(GC_ADDR, GC_CMD_REPROG, 1'b1);
		chk(ack, 1'b1);
		chk(n[3], 1);
		chk(evt[0].gc_status, 1'b1);
		wr(1, 32'h108);
		repeat (6) @(posedge clk);
		mdl[1] = 32'h8;
		chk(evt[0].gc_status, 1'b0);
		rdchk(1);
		g = 8'($urandom) | 8'h01;
		wr(0, {24'h0, g});
		wr(1, 32'h18);
		frame(GC_ADDR, g, 1'b1);
		chk(evt[0].hwgc_status, 1'b1);
		frame(GC_ADDR, GC_CMD_RESET, 1'b1);
		chk(n[2], 1);
		mdl[0] = 0;
		mdl[1] = 0;
		rdchk(0);
		rdchk(1);
		$display("general call test done");
		for (int k = 0; k < 3; k++) begin
			b = n;
			wr(1, cfgs[k]);
			frame({own[0] ^ 7'(k / 2), 1'b1}, 8'h0, 1'b0);
			repeat (10) @(posedge clk);
			chk(ack, k < 2);
			chk(n[0] - b[0], k == 1);
			chk(n[1] - b[1], k == 1);
		end
		chk(lat <= TXREQ_SYS_CYCLES, 1'b1);
		chk({pouts[1], evt[1]}, 32'h0);
		chk({pouts[0].scl_o, pouts[0].sda_o}, 32'h0);
		$display("stop and request test done");
		print_verdict();
	end
endmodule // tb_iscg_top
